// [design/serial_audio_input_cfg.svh]
// register map, field positions, reset values and timing counts of the serial audio input port
`ifndef SERIAL_AUDIO_INPUT_CFG_SVH
`define SERIAL_AUDIO_INPUT_CFG_SVH
// register indices; byte address is four times the index
`define IDX_RATE        10'h049
`define IDX_SAMPLE      10'h04e
`define IDX_FORMAT      10'h04f
`define IDX_CTRL        10'h050
// format fields
`define FMT_ORDER       4
`define FMT_JUSTIFY     3
`define FMT_POLARITY    2
`define FMT_EDGE        1
`define FMT_OFFSET      0
`define FMT_RESET       8'h16
`define CTRL_RESET      8'h00
`define CTRL_AC97       0
// timing, frame periods in ns at the 8 ns clock
`define MCLK_NS         8
`define T48_44_NS       21750
`define T44_32_NS       26960
`define TMIN_NS         18000
`define TMAX_NS         35000
`define T48_44_CYC      (`T48_44_NS / `MCLK_NS)
`define T44_32_CYC      (`T44_32_NS / `MCLK_NS)
`define TMIN_CYC        ((`TMIN_NS + `MCLK_NS - 1) / `MCLK_NS)
`define TMAX_CYC        (`TMAX_NS / `MCLK_NS)
// mixer rate phase increments for a 32-bit accumulator at 125 MHz
`define MCLK_HZ         64'd125000000
`define MIX48_INC       ((64'd48000 * 64'h100000000) / `MCLK_HZ)
`define MIX22_INC       ((64'd22050 * 64'h100000000) / `MCLK_HZ)
`endif

// [design/serial_audio_input_pkg.sv]
// types shared by the serial audio input port
package serial_audio_input_pkg;
  typedef struct packed {
    logic order;
    logic justify_direction;
    logic left_channel_polarity;
    logic edge_rise;
    logic one_bit_offset;
  } fmt_s;
  typedef struct packed {
    logic [15:0] left;
    logic [15:0] right;
  } pair_s;
  typedef enum logic [1:0] {
    RATE_32 = 2'b00,
    RATE_48 = 2'b10,
    RATE_44 = 2'b11
  } rate_e;
endpackage : serial_audio_input_pkg

// [design/serial_audio_input.sv]
// serial audio input port: bit-clock receiver, rate detect, mixer feed and APB registers
//
// Summary of operation
// - bit order 1 takes the first aligned bit as MSB, 0 as LSB
// - justify 1 collects forward from half-period start, 0 aligns backward to its end
// - polarity 1 means high word clock is left, 0 means low is left
// - edge 1 samples data on rising bit clock, 0 on falling
// - offset 1 takes the first bit one bit clock after the word-clock edge with justify 1; with justify 0 the last bit falls one past it
// - code 16h is right-justified, 64 clocks per frame, LSB ends at the edge
// - format register resets to 16h
// - code 1Bh is the one-bit-delayed justified format, left on low
// - code 1Dh is left-justified with a one-bit delay, left on high
// - detected rate code: 11 is 44.1 kHz, 10 is 48 kHz, 0X is 32 kHz
// - only streams with a frame period of 18000 to 35000 ns are accepted
// - samples are rate-converted or passed straight, and added into the digital mix
// - with the newer codec link the mix runs at 48 kHz, 48 kHz passes straight
// - without that link the mix runs at 22.05 kHz and all input is converted
`include "serial_audio_input_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module serial_audio_input #(
  parameter int unsigned PERIOD_MAX_CYC = `TMAX_CYC
) (
  // system
  input  wire logic        MCLK,
  input  wire logic        SRST,
  // apb slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // serial audio link, all driven by the source
  input  wire logic        BCLK,
  input  wire logic        LRCLK,
  input  wire logic        SDATA,
  // digital mix
  input  wire logic [15:0] MIX_IN_L,
  input  wire logic [15:0] MIX_IN_R,
  output logic      [15:0] MIX_OUT_L,
  output logic      [15:0] MIX_OUT_R,
  output logic             MIX_VALID
);
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] sat_add(input logic [15:0] a, input logic [15:0] b);
    logic [16:0] s;
    s = {a[15], a} + {b[15], b};
    if (s[16] != s[15]) sat_add = s[16] ? 16'h8000 : 16'h7fff;
    else sat_add = s[15:0];
  endfunction : sat_add

  function automatic logic [15:0] bit_rev(input logic [15:0] w);
    bit_rev = '0;
    for (int i = 0; i < 16; i++) bit_rev[i] = w[15 - i];
  endfunction : bit_rev

  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic [7:0]                  fmt_reg;
  logic [7:0]                  ctrl_reg;
  serial_audio_input_pkg::rate_e rate;
  logic                        rate_ok;
  serial_audio_input_pkg::pair_s last_pair;
  logic [9:0]                  idx;
  logic                        mapped;
  logic                        wr_acc;

  assign idx    = PADDR[11:2];
  assign mapped = (idx == `IDX_RATE) || (idx == `IDX_SAMPLE) || (idx == `IDX_FORMAT) || (idx == `IDX_CTRL);
  assign wr_acc = PSEL && PENABLE && PWRITE && mapped;
  // zero wait states keeps the slave simple; every access ends in its first access cycle
  assign PREADY  = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !mapped;

  always_ff @(posedge MCLK) begin
    if (SRST) begin
      fmt_reg <= `FMT_RESET;
    end else if (wr_acc && idx == `IDX_FORMAT) begin
      fmt_reg <= {3'h0, PWDATA[4:0]};
    end
  end

  always_ff @(posedge MCLK) begin
    if (SRST) begin
      ctrl_reg <= `CTRL_RESET;
    end else if (wr_acc && idx == `IDX_CTRL) begin
      ctrl_reg <= {7'h00, PWDATA[`CTRL_AC97]};
    end
  end

  // read data is loaded in the setup cycle so it stands through the access cycle
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      PRDATA <= 32'h0;
    end else if (PSEL && !PENABLE) begin
      case (idx)
        `IDX_FORMAT: PRDATA <= {24'h0, fmt_reg};
        `IDX_CTRL:   PRDATA <= {24'h0, ctrl_reg};
        `IDX_RATE:   PRDATA <= {29'h0, rate_ok, rate};
        `IDX_SAMPLE: PRDATA <= {last_pair.right, last_pair.left};
        default:     PRDATA <= 32'h0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // link domain: reset and format pass three flops; a change counts once the last two agree
  serial_audio_input_pkg::fmt_s fmt_s1;
  serial_audio_input_pkg::fmt_s fmt_s2;
  serial_audio_input_pkg::fmt_s fmt_s3;
  serial_audio_input_pkg::fmt_s fmt;
  logic                         brst_s1;
  logic                         brst_s2;
  logic                         brst_s3;
  logic                         brst;

  always_ff @(posedge BCLK) begin
    brst_s1 <= SRST;
    brst_s2 <= brst_s1;
    brst_s3 <= brst_s2;
    if (brst_s2 == brst_s3) brst <= brst_s3;
  end

  // format bits may land on different edges; the agree test filters a torn word
  always_ff @(posedge BCLK) begin
    fmt_s1 <= fmt_reg[4:0];
    fmt_s2 <= fmt_s1;
    fmt_s3 <= fmt_s2;
    if (fmt_s2 == fmt_s3) fmt <= fmt_s3;
  end

  // the port never drives the link, it only samples it
  logic r_dat;
  logic r_lr;
  logic f_dat;
  logic f_lr;

  always_ff @(posedge BCLK) begin
    r_dat <= SDATA;
    r_lr  <= LRCLK;
  end

  always_ff @(negedge BCLK) begin
    f_dat <= SDATA;
    f_lr  <= LRCLK;
  end

  logic        b;
  logic        lr;
  logic        prev_lr;
  logic        new_half;
  logic [7:0]  cnt;
  logic [7:0]  next_cnt;
  logic [15:0] sh;
  logic [15:0] next_sh;
  logic        done;
  logic        done_left;
  logic [15:0] word;

  always_comb begin
    b        = fmt.edge_rise ? r_dat : f_dat;
    lr       = fmt.edge_rise ? r_lr : f_lr;
    new_half = lr != prev_lr;
    next_cnt = new_half ? 8'h00 : (cnt == 8'hff ? cnt : cnt + 8'h01);
    next_sh  = {sh[14:0], b};
    word     = 16'h0;
    done     = 1'b0;
    done_left = 1'b0;
    if (fmt.justify_direction) begin
      // forward: 16 bits counted from the edge, shifted by the offset
      done      = next_cnt == 8'(15 + fmt.one_bit_offset);
      word      = next_sh;
      done_left = lr == fmt.left_channel_polarity;
    end else begin
      // backward: last 16 bits before the edge, or one bit past it
      done      = new_half;
      word      = fmt.one_bit_offset ? next_sh : sh;
      done_left = prev_lr == fmt.left_channel_polarity;
    end
    if (!fmt.order) word = bit_rev(word);
  end

  logic [15:0]                  word_l;
  serial_audio_input_pkg::pair_s link_pair;
  logic                         pair_tog;

  always_ff @(posedge BCLK) begin
    if (brst) begin
      prev_lr   <= 1'b0;
      cnt       <= 8'h00;
      sh        <= 16'h0;
      word_l    <= 16'h0;
      link_pair <= '0;
      pair_tog  <= 1'b0;
    end else begin
      prev_lr <= lr;
      cnt     <= next_cnt;
      sh      <= next_sh;
      if (done && done_left) word_l <= word;
      // pair handed over on the right word; it stays still for about a frame
      if (done && !done_left) begin
        link_pair <= '{left: word_l, right: word};
        pair_tog  <= !pair_tog;
      end
    end
  end

  chk_fwd_align: assert property (@(posedge BCLK) disable iff (brst)
    fmt.justify_direction && done |-> next_cnt == 8'(15 + fmt.one_bit_offset))
    else $error("forward word not completed at sixteenth bit");
  chk_msb_order: assert property (@(posedge BCLK) disable iff (brst)
    done && fmt.order && fmt.justify_direction |-> word[0] == b)
    else $error("msb-first word does not end with last bit");
  chk_left_pick: assert property (@(posedge BCLK) disable iff (brst)
    done && done_left && fmt.justify_direction |=> word_l == $past(word) && $past(lr) == $past(fmt.left_channel_polarity))
    else $error("left word stored on wrong word-clock level");
  chk_back_done: assert property (@(posedge BCLK) disable iff (brst)
    !fmt.justify_direction && new_half |-> done)
    else $error("backward word not completed at word-clock edge");
  chk_pair_hand: assert property (@(posedge BCLK) disable iff (brst)
    done && !done_left |=> pair_tog != $past(pair_tog))
    else $error("right word did not hand over a pair");

  ////////////////////////////////////////////////////////////////////////////
  // pair event into the register clock: three flops, second and third agree
  logic tg1;
  logic tg2;
  logic tg3;
  logic tg_lvl;
  logic pair_ev;

  always_ff @(posedge MCLK) begin
    if (SRST) begin
      tg1    <= 1'b0;
      tg2    <= 1'b0;
      tg3    <= 1'b0;
      tg_lvl <= 1'b0;
    end else begin
      tg1 <= pair_tog;
      tg2 <= tg1;
      tg3 <= tg2;
      if (tg2 == tg3) tg_lvl <= tg3;
    end
  end

  assign pair_ev = (tg2 == tg3) && (tg3 != tg_lvl);

  // rate detection from the frame period in clock cycles
  logic [15:0] per_cnt;
  logic        per_ok;
  serial_audio_input_pkg::rate_e next_rate;

  always_comb begin
    per_ok = (per_cnt >= 16'(`TMIN_CYC)) && (per_cnt <= 16'(PERIOD_MAX_CYC));
    if (per_cnt < 16'(`T48_44_CYC)) next_rate = serial_audio_input_pkg::RATE_48;
    else if (per_cnt < 16'(`T44_32_CYC)) next_rate = serial_audio_input_pkg::RATE_44;
    else next_rate = serial_audio_input_pkg::RATE_32;
  end

  always_ff @(posedge MCLK) begin
    if (SRST) begin
      per_cnt   <= 16'h0;
      rate      <= serial_audio_input_pkg::RATE_32;
      rate_ok   <= 1'b0;
      last_pair <= '0;
    end else if (pair_ev) begin
      per_cnt   <= 16'h1;
      rate      <= next_rate;
      rate_ok   <= per_ok;
      last_pair <= link_pair;
    end else if (per_cnt != 16'hffff) begin
      per_cnt <= per_cnt + 16'h1;
    end
  end

  chk_rate_code: assert property (@(posedge MCLK) disable iff (SRST)
    pair_ev && per_cnt < 16'(`T48_44_CYC) |=> rate == serial_audio_input_pkg::RATE_48)
    else $error("48 kHz period not reported as 10");

  ////////////////////////////////////////////////////////////////////////////
  // mixer: zero-order hold onto the mix rate, or straight through at 48 kHz
  logic [31:0] phase;
  logic [32:0] next_phase;
  logic        tick;
  logic        ac97;
  logic        pass;
  logic [15:0] held_l;
  logic [15:0] held_r;
  logic [15:0] src_l;
  logic [15:0] src_r;
  logic        fire;

  assign ac97 = ctrl_reg[`CTRL_AC97];
  // mix rate is 48 kHz with the newer codec link, 22.05 kHz otherwise
  assign next_phase = {1'b0, phase} + (ac97 ? 33'(`MIX48_INC) : 33'(`MIX22_INC));
  assign tick = next_phase[32];
  assign pass = ac97 && rate_ok && rate == serial_audio_input_pkg::RATE_48;
  assign src_l = pass ? last_pair.left : held_l;
  assign src_r = pass ? last_pair.right : held_r;
  // hold conversion is cheap; aliasing is the price of no interpolator
  assign fire = rate_ok && (pass ? pair_ev : tick);

  always_ff @(posedge MCLK) begin
    if (SRST) begin
      phase  <= 32'h0;
      held_l <= 16'h0;
      held_r <= 16'h0;
    end else begin
      phase <= next_phase[31:0];
      if (rate_ok) begin
        held_l <= last_pair.left;
        held_r <= last_pair.right;
      end
    end
  end

  always_ff @(posedge MCLK) begin
    if (SRST) begin
      MIX_OUT_L <= 16'h0;
      MIX_OUT_R <= 16'h0;
      MIX_VALID <= 1'b0;
    end else begin
      MIX_VALID <= fire;
      if (fire) begin
        MIX_OUT_L <= sat_add(src_l, MIX_IN_L);
        MIX_OUT_R <= sat_add(src_r, MIX_IN_R);
      end
    end
  end

  chk_fmt_reset: assert property (@(posedge MCLK)
    SRST |=> fmt_reg == `FMT_RESET)
    else $error("format register not 16h after reset");
  chk_resv_zero: assert property (@(posedge MCLK) disable iff (SRST)
    PSEL && !PENABLE && idx == `IDX_FORMAT |=> PRDATA[31:5] == 27'h0)
    else $error("reserved format bits read nonzero");
  chk_pass_thru: assert property (@(posedge MCLK) disable iff (SRST)
    pass && pair_ev |=> MIX_VALID && MIX_OUT_L == sat_add($past(last_pair.left), $past(MIX_IN_L)))
    else $error("48 kHz sample not passed straight to mix");
  chk_mix_tick: assert property (@(posedge MCLK) disable iff (SRST)
    !ac97 && MIX_VALID |-> $past(tick) && $past(rate_ok))
    else $error("mix output off the 22.05 kHz tick");
  chk_mix_sum: assert property (@(posedge MCLK) disable iff (SRST)
    MIX_VALID |-> MIX_OUT_R == sat_add($past(src_r), $past(MIX_IN_R)))
    else $error("mix sum wrong");
  chk_bad_rate: assert property (@(posedge MCLK) disable iff (SRST)
    !rate_ok |=> !MIX_VALID)
    else $error("unsupported rate reached the mix");

  ////////////////////////////////////////////////////////////////////////////
  // register side checks
  chk_fmt_write: assert property (@(posedge MCLK) disable iff (SRST)
    PSEL && PENABLE && PWRITE && idx == `IDX_FORMAT |=> fmt_reg == {3'h0, $past(PWDATA[4:0])})
    else $error("format write not taken");
  chk_slverr_map: assert property (@(posedge MCLK) disable iff (SRST)
    PSEL && PENABLE && !mapped |-> PSLVERR && PREADY)
    else $error("unmapped access not flagged");
  chk_rate_hold: assert property (@(posedge MCLK) disable iff (SRST)
    !pair_ev |=> $stable(rate) && $stable(last_pair))
    else $error("rate or sample changed without a pair");
  chk_mix_hold: assert property (@(posedge MCLK) disable iff (SRST)
    !MIX_VALID |-> $stable(MIX_OUT_L) && $stable(MIX_OUT_R))
    else $error("mix output moved without valid");
  chk_ready_high: assert property (@(posedge MCLK) disable iff (SRST)
    PSEL && PENABLE |-> PREADY)
    else $error("access not answered at once");
endmodule : serial_audio_input
`default_nettype wire

// [verif/audio_source_model.sv]
// serial audio source model driving bit clock, word clock and data
`timescale 1ns/1ps
`default_nettype none
module audio_source_model (
  // bench control
  input  wire logic                          run,
  input  wire serial_audio_input_pkg::fmt_s  fmt,
  input  wire logic [11:0]                   half,
  input  wire serial_audio_input_pkg::pair_s pair,
  // link toward the port
  output logic                               BCLK,
  output logic                               LRCLK,
  output logic                               SDATA
);
  logic [15:0] w;
  logic [15:0] prev;
  logic [15:0] src;
  int          st;
  int          j;
  ////////////////////////////////////////////////////////////
  // bit clock stands still while run is low
  initial BCLK = 1'b0;
  always #6 BCLK = run ? ~BCLK : 1'b0;
  ////////////////////////////////////////////////////////////
  initial begin
    LRCLK = 1'b0;
    SDATA = 1'b0;
    w = '0;
    forever begin
      for (int h = 0; h < 2; h++) begin
        prev = w;
        w = h ? pair.right : pair.left;
        st = fmt.justify_direction ? 0 : int'(half) - 16;
        st = st + int'(fmt.one_bit_offset);
        for (int k = 0; k < half; k++) begin
          // launch on the edge opposite the latch edge, half a bit of setup
          if (fmt.edge_rise) @(negedge BCLK); else @(posedge BCLK);
          LRCLK = fmt.left_channel_polarity ^ h[0];
          src = (k < st) ? prev : w;
          j = (k < st) ? k + int'(half) - st : k - st;
          // unused slots toggle so stray bits are not taken as quiet zeros
          if (j >= 0 && j < 16) SDATA = fmt.order ? src[15 - j] : src[j];
          else SDATA = k[0];
        end
      end
    end
  end
endmodule : audio_source_model
`default_nettype wire

// [verif/test_serial_audio_input.sv]
// self-checking bench for the serial audio input port
`include "serial_audio_input_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module test_serial_audio_input;
  localparam logic [11:0] A_FMT  = {`IDX_FORMAT, 2'b00};
  localparam logic [11:0] A_RATE = {`IDX_RATE, 2'b00};
  localparam logic [11:0] A_SMP  = {`IDX_SAMPLE, 2'b00};
  localparam logic [11:0] A_CTRL = {`IDX_CTRL, 2'b00};
  localparam logic [4:0]  CODES [6] = '{5'h16, 5'h1b, 5'h1d, 5'h00, 5'h09, 5'h17};
  localparam logic [11:0] HALVES [3] = '{12'd945, 12'd1302, 12'd868};
  localparam logic [2:0]  RATES [3] = '{3'b111, 3'b100, 3'b110};
  logic                          mclk;
  logic                          srst;
  logic                          psel;
  logic                          penable;
  logic                          pwrite;
  logic [11:0]                   paddr;
  logic [31:0]                   pwdata;
  logic [31:0]                   prdata;
  logic                          pready;
  logic                          pslverr;
  logic                          bclk;
  logic                          lrclk;
  logic                          sdata;
  logic [15:0]                   mix_in_l;
  logic [15:0]                   mix_in_r;
  logic [15:0]                   mix_out_l;
  logic [15:0]                   mix_out_r;
  logic                          mix_valid;
  logic                          run;
  serial_audio_input_pkg::fmt_s  fmt;
  logic [11:0]                   half;
  serial_audio_input_pkg::pair_s pair;
  logic [31:0]                   r;
  logic                          e;
  logic [15:0]                   lv;
  logic [15:0]                   rv;
  int                            n;
  int                            errors;
  int                            checks_done;
  ////////////////////////////////////////////////////////////
  serial_audio_input serial_audio_input_inst (
    .MCLK(mclk), .SRST(srst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .BCLK(bclk), .LRCLK(lrclk), .SDATA(sdata), .MIX_IN_L(mix_in_l), .MIX_IN_R(mix_in_r),
    .MIX_OUT_L(mix_out_l), .MIX_OUT_R(mix_out_r), .MIX_VALID(mix_valid)
  );
  audio_source_model audio_source_model_inst (
    .run(run), .fmt(fmt), .half(half), .pair(pair), .BCLK(bclk), .LRCLK(lrclk), .SDATA(sdata)
  );
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  ////////////////////////////////////////////////////////////
  task automatic complete_run;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : complete_run
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int t;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    t = 0;
    do begin
      @(posedge mclk);
      t++;
    end while (pready !== 1'b1 && t < 16);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // frames are counted on the word clock, then a margin for the crossing
  task automatic settle(input int frames);
    repeat (frames) @(posedge lrclk);
    repeat (20) @(posedge mclk);
  endtask : settle
  task automatic wait_mix;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (mix_valid !== 1'b1 && n < 8000);
  endtask : wait_mix
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (95000) @(posedge mclk);
    errors++;
    complete_run();
  end
  initial begin
    srst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    mix_in_l = '0;
    mix_in_r = '0;
    run = 1'b1;
    fmt = serial_audio_input_pkg::fmt_s'(5'h16);
    half = 12'd32;
    pair = '0;
    errors = 0;
    checks_done = 0;
    repeat (6) @(posedge mclk);
    srst <= 1'b0;
    apb(1'b0, A_FMT, 32'h0);
    chk(r, 32'h16);
    apb(1'b1, A_FMT, 32'hffffffff);
    apb(1'b0, A_FMT, 32'h0);
    chk(r, 32'h1f);
    apb(1'b1, 12'h000, 32'h1);
    chk({31'h0, e}, 32'h1);
    apb(1'b0, 12'h000, 32'h0);
    chk({r[30:0], e}, 32'h1);
    // six format codes, 64 clocks per frame
    for (int i = 0; i < 6; i++) begin
      lv = 16'ha5c1 + 16'(i);
      rv = 16'h3c5a ^ 16'(i);
      apb(1'b1, A_FMT, {27'h0, CODES[i]});
      fmt <= serial_audio_input_pkg::fmt_s'(CODES[i]);
      pair <= {lv, rv};
      settle(8);
      apb(1'b0, A_SMP, 32'h0);
      chk(r, {rv, lv});
    end
    // long halves give real sample rates on the 12 ns bit clock
    apb(1'b1, A_FMT, 32'h1d);
    fmt <= serial_audio_input_pkg::fmt_s'(5'h1d);
    for (int i = 0; i < 3; i++) begin
      half <= HALVES[i];
      settle(4);
      apb(1'b0, A_RATE, 32'h0);
      chk({29'h0, r[2:0]}, {29'h0, RATES[i]});
    end
    apb(1'b1, A_CTRL, 32'h0);
    pair <= {16'h1234, 16'hfff0};
    mix_in_l <= 16'h0100;
    mix_in_r <= 16'h0020;
    settle(3);
    wait_mix();
    wait_mix();
    chk(32'(n >= 5668 && n <= 5670), 32'h1);
    chk({mix_out_l, mix_out_r}, 32'h1334_0010);
    apb(1'b1, A_CTRL, 32'h1);
    pair <= {16'h7000, 16'h8100};
    mix_in_l <= 16'h2000;
    mix_in_r <= 16'h9000;
    settle(3);
    wait_mix();
    wait_mix();
    chk(32'(n >= 2600 && n <= 2608), 32'h1);
    chk({mix_out_l, mix_out_r}, 32'h7fff_8000);
    // a frame far too short must stop the mix feed
    half <= 12'd32;
    settle(8);
    apb(1'b0, A_RATE, 32'h0);
    chk({31'h0, r[2]}, 32'h0);
    n = 0;
    repeat (6000) begin
      @(posedge mclk);
      if (mix_valid !== 1'b0) n++;
    end
    chk(32'(n), 32'h0);
    complete_run();
  end
endmodule : test_serial_audio_input
`default_nettype wire
